/* File: hdl/msor_handover_decode.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msor_params.svh"
module msor_handover_decode
(
  input wire logic [4:0] code,
  output msor_pkg::msor_word_t freq_dhz,
  output logic valid
);
  import msor_pkg::*;
  wire [15:0] n_w;
  wire [15:0] r0_w;
  wire [15:0] r1_w;
  // low four bits are the multiplier n
  assign n_w = {12'h000, code[3:0]};
  assign r0_w = 16'(n_w * `MSOR_RANGE0_STEP_DHZ);
  assign r1_w = 16'((n_w + 16'h0001) * `MSOR_RANGE1_STEP_DHZ);
  // top bit picks the range; range 0 code zero has no meaning
  assign freq_dhz = code[4] ? r1_w : r0_w;
  assign valid = code[4] | (code[3:0] != 4'h0);
endmodule : msor_handover_decode
`default_nettype wire

/* File: hdl/msor_option_regs.sv */
`timescale 1ns/1ps
`default_nettype none
`include "msor_params.svh"
module msor_option_regs
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire msor_pkg::msor_byte_t reg_wdata,
  output msor_pkg::msor_byte_t reg_rdata,
  output logic reg_hit,
  output logic [1:0] stationary_judge_window,
  output msor_pkg::msor_word_t stationary_window_ms,
  output logic [1:0] sense_advance_angle,
  output logic [7:0] sense_advance_degrees,
  output logic initial_speed_detect_enable,
  output logic reverse_drive_enable,
  output logic [1:0] reverse_drive_threshold,
  output logic [1:0] open_loop_current,
  output logic [2:0] open_loop_ramp_rate,
  output logic [2:0] brake_duration,
  output logic brake_enable,
  output msor_pkg::msor_word_t brake_duration_ms,
  output logic [1:0] control_coefficient,
  output logic [2:0] startup_accel_second_order,
  output logic [2:0] startup_accel_first_order,
  output logic [4:0] handover_threshold,
  output msor_pkg::msor_word_t handover_freq_dhz,
  output logic handover_valid,
  output logic [2:0] align_duration,
  output msor_pkg::msor_word_t align_duration_ms,
  output logic no_motor_fault_enable,
  output logic [2:0] fault_detect_enables,
  output logic inductive_surge_protect_enable,
  output logic mechanical_surge_protect_enable,
  output logic mechanical_surge_protect_limit,
  output logic sense_release_state
);
  import msor_pkg::*;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function automatic msor_sel_e msor_decode(input logic [7:0] a);
    msor_sel_e s;
    s = msor_sel_none;
    if (a == `MSOR_ADDR_SPEED_DETECT_REVERSE)
      s = msor_sel_opt1;
    else if (a == `MSOR_ADDR_OPEN_LOOP_CURRENT_BRAKE)
      s = msor_sel_opt2;
    else if (a == `MSOR_ADDR_STARTUP_ACCELERATION)
      s = msor_sel_opt3;
    else if (a == `MSOR_ADDR_HANDOVER_ALIGN)
      s = msor_sel_opt4;
    else if (a == `MSOR_ADDR_FAULT_SURGE)
      s = msor_sel_opt5;
    return s;
  endfunction : msor_decode

  msor_sel_e sel_w;
  assign sel_w = msor_decode(reg_addr);
  assign reg_hit = (sel_w != msor_sel_none);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // whole-byte writes only, so fields of one register never tear
  msor_byte_t speed_detect_reverse_options_q;
  msor_byte_t open_loop_current_brake_options_q;
  msor_byte_t startup_acceleration_options_q;
  msor_byte_t handover_align_options_q;
  msor_byte_t fault_surge_options_q;
  msor_byte_t rdata_q;
  msor_byte_t rdata_d;

  wire wr1_w = reg_write && (sel_w == msor_sel_opt1);
  wire wr2_w = reg_write && (sel_w == msor_sel_opt2);
  wire wr3_w = reg_write && (sel_w == msor_sel_opt3);
  wire wr4_w = reg_write && (sel_w == msor_sel_opt4);
  wire wr5_w = reg_write && (sel_w == msor_sel_opt5);

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      speed_detect_reverse_options_q <= `MSOR_RESET_VALUE;
      open_loop_current_brake_options_q <= `MSOR_RESET_VALUE;
      startup_acceleration_options_q <= `MSOR_RESET_VALUE;
      handover_align_options_q <= `MSOR_RESET_VALUE;
      fault_surge_options_q <= `MSOR_RESET_VALUE;
      rdata_q <= `MSOR_RESET_VALUE;
    end
    else
    begin
      if (wr1_w) speed_detect_reverse_options_q <= reg_wdata;
      if (wr2_w) open_loop_current_brake_options_q <= reg_wdata;
      if (wr3_w) startup_acceleration_options_q <= reg_wdata;
      if (wr4_w) handover_align_options_q <= reg_wdata;
      if (wr5_w) fault_surge_options_q <= reg_wdata;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // readback
  // ----------------------------------------------------------------
  // registered read: data appears one edge after the address; unmapped reads zero
  always_comb
  begin
    unique case (sel_w)
      msor_sel_opt1: rdata_d = speed_detect_reverse_options_q;
      msor_sel_opt2: rdata_d = open_loop_current_brake_options_q;
      msor_sel_opt3: rdata_d = startup_acceleration_options_q;
      msor_sel_opt4: rdata_d = handover_align_options_q;
      msor_sel_opt5: rdata_d = fault_surge_options_q;
      msor_sel_none: rdata_d = 8'h00;
      // the select enum leaves two codes unused
      default: rdata_d = 8'h00;
    endcase
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // first option register
  // ----------------------------------------------------------------
  assign stationary_judge_window = speed_detect_reverse_options_q[7:6];
  // each code doubles the window
  assign stationary_window_ms = 16'(`MSOR_STATIONARY_BASE_MS << stationary_judge_window);
  assign sense_advance_angle = speed_detect_reverse_options_q[5:4];
  // 30 degrees per step above a 30 degree base
  assign sense_advance_degrees = 8'({6'h00, sense_advance_angle} * 8'h1e + 8'h1e);
  assign initial_speed_detect_enable = speed_detect_reverse_options_q[3];
  assign reverse_drive_enable = speed_detect_reverse_options_q[2];
  assign reverse_drive_threshold = speed_detect_reverse_options_q[1:0];

  // ----------------------------------------------------------------
  // second option register
  // ----------------------------------------------------------------
  assign open_loop_current = open_loop_current_brake_options_q[7:6];
  assign open_loop_ramp_rate = open_loop_current_brake_options_q[5:3];
  assign brake_duration = open_loop_current_brake_options_q[2:0];
  assign brake_enable = (brake_duration != 3'h0);
  // halving is approximate; the engine should treat these as nominal
  assign brake_duration_ms = brake_enable ?
    16'(`MSOR_BRAKE_LONGEST_MS >> (brake_duration - 3'h1)) : 16'h0000;

  // ----------------------------------------------------------------
  // third option register
  // ----------------------------------------------------------------
  assign control_coefficient = startup_acceleration_options_q[7:6];
  assign startup_accel_second_order = startup_acceleration_options_q[5:3];
  assign startup_accel_first_order = startup_acceleration_options_q[2:0];

  // ----------------------------------------------------------------
  // fourth option register
  // ----------------------------------------------------------------
  assign handover_threshold =
    handover_align_options_q[`MSOR_HANDOVER_HI:`MSOR_HANDOVER_LO];
  msor_handover_decode u_handover_decode (
    .code(handover_threshold),
    .freq_dhz(handover_freq_dhz),
    .valid(handover_valid)
  );
  assign align_duration = handover_align_options_q[`MSOR_ALIGN_HI:`MSOR_ALIGN_LO];
  assign align_duration_ms = 16'(`MSOR_ALIGN_LONGEST_MS >> align_duration);

  // ----------------------------------------------------------------
  // fifth option register
  // ----------------------------------------------------------------
  assign no_motor_fault_enable = fault_surge_options_q[7];
  // bit 2 velocity constant, bit 1 speed, bit 0 lock current limit
  assign fault_detect_enables = fault_surge_options_q[6:4];
  assign inductive_surge_protect_enable = fault_surge_options_q[3];
  assign mechanical_surge_protect_enable = fault_surge_options_q[2];
  // 0 limits to supply, 1 limits to 24 V
  assign mechanical_surge_protect_limit = fault_surge_options_q[1];
  // 0 brakes on release, 1 floats outputs
  assign sense_release_state = fault_surge_options_q[0];
endmodule : msor_option_regs
`default_nettype wire

/* File: hdl/msor_params.svh */
`ifndef MSOR_PARAMS_SVH
`define MSOR_PARAMS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MSOR_ADDR_SPEED_DETECT_REVERSE 8'h23
`define MSOR_ADDR_OPEN_LOOP_CURRENT_BRAKE 8'h24
`define MSOR_ADDR_STARTUP_ACCELERATION 8'h25
`define MSOR_ADDR_HANDOVER_ALIGN 8'h26
`define MSOR_ADDR_FAULT_SURGE 8'h27
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MSOR_RESET_VALUE 8'h00
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MSOR_HANDOVER_HI 7
`define MSOR_HANDOVER_LO 3
`define MSOR_ALIGN_HI 2
`define MSOR_ALIGN_LO 0
// ----------------------------------------------------------------
// timing in milliseconds and scaled decode units
// ----------------------------------------------------------------
`define MSOR_STATIONARY_BASE_MS 16'h0050
`define MSOR_RANGE0_STEP_DHZ 16'h0008
`define MSOR_RANGE1_STEP_DHZ 16'h0080
`define MSOR_BRAKE_LONGEST_MS 16'h0a8c
`define MSOR_ALIGN_LONGEST_MS 16'h14b4
`endif

/* File: hdl/msor_pkg.sv */
package msor_pkg;
  typedef logic [7:0] msor_byte_t;
  typedef logic [15:0] msor_word_t;
  typedef enum logic [2:0] {
    msor_sel_none,
    msor_sel_opt1,
    msor_sel_opt2,
    msor_sel_opt3,
    msor_sel_opt4,
    msor_sel_opt5
  } msor_sel_e;
endpackage : msor_pkg

/* File: tb/msor_host.sv */
`timescale 1ns/1ps
`default_nettype none
module msor_host
(
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic reg_write,
  output msor_pkg::msor_byte_t reg_wdata,
  input wire msor_pkg::msor_byte_t reg_rdata
);
  import msor_pkg::*;
  // ----
  // host side, changes only at falling edges
  // ----
  initial
  begin
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input msor_byte_t d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'b1;
    @(negedge ref_clk);
    reg_write = 1'b0;
    // data not qualified any more, so do not leave the old value standing
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output msor_byte_t d);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : msor_host
`default_nettype wire

/* File: tb/msor_props.sv */
`timescale 1ns/1ps
`default_nettype none
module msor_props
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire msor_pkg::msor_byte_t reg_wdata,
  input wire msor_pkg::msor_byte_t reg_rdata,
  input wire logic reg_hit,
  input wire logic [2:0] brake_duration,
  input wire logic brake_enable,
  input wire logic [4:0] handover_threshold,
  input wire logic handover_valid,
  input wire logic [2:0] align_duration,
  input wire logic no_motor_fault_enable,
  input wire logic [2:0] fault_detect_enables,
  input wire logic inductive_surge_protect_enable,
  input wire logic mechanical_surge_protect_enable,
  input wire logic mechanical_surge_protect_limit,
  input wire logic sense_release_state
);
  import msor_pkg::*;
  // ----
  // checks
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  property p_rd; (reg_write && reg_hit) ##1 (!reg_write && $stable(reg_addr))
    |=> reg_rdata == $past(reg_wdata, 2); endproperty
  a_rd: assert property (p_rd) else $error("read back differs from write");
  property p_un; !reg_hit |=> reg_rdata == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read not zero");
  property p_brk; brake_enable == (brake_duration != 3'h0); endproperty
  a_brk: assert property (p_brk) else $error("brake enable wrong");
  property p_hv; handover_valid == (handover_threshold != 5'h00); endproperty
  a_hv: assert property (p_hv) else $error("handover valid wrong");
  property p_f5; reg_write && reg_addr == 8'h27 |=> {no_motor_fault_enable,
    fault_detect_enables, inductive_surge_protect_enable, mechanical_surge_protect_enable,
    mechanical_surge_protect_limit, sense_release_state} == $past(reg_wdata); endproperty
  a_f5: assert property (p_f5) else $error("fault field update wrong");
  property p_o4; reg_write && reg_addr == 8'h26 |=>
    {handover_threshold, align_duration} == $past(reg_wdata); endproperty
  a_o4: assert property (p_o4) else $error("handover field update wrong");
  property p_o2; reg_write && reg_addr == 8'h24 |=> brake_duration == $past(reg_wdata[2:0]);
  endproperty
  a_o2: assert property (p_o2) else $error("brake field update wrong");
  // a stray write path would show up as a field change without a write
  property p_hold; !(reg_write && reg_addr == 8'h26) |=>
    $stable({handover_threshold, align_duration}); endproperty
  a_hold: assert property (p_hold) else $error("field changed without write");
  property p_hit; reg_hit == (reg_addr >= 8'h23 && reg_addr <= 8'h27); endproperty
  a_hit: assert property (p_hit) else $error("address decode wrong");
  c_wr5: cover property (reg_write && reg_addr == 8'h27);
  c_un: cover property (!reg_hit ##1 reg_rdata == 8'h00);
  c_top: cover property (handover_threshold[4]);
endmodule : msor_props
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import msor_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] ra;
  logic rw, hit, initial_speed_detection, rde, be, hv, nm, ise, mse, msl, srs;
  msor_byte_t wd, rdat;
  logic [1:0] sjw, saa, rdt, olc, cc;
  logic [2:0] olr, bd, sa2, sa1, ad, fde;
  logic [4:0] ht;
  logic [7:0] deg;
  msor_word_t win, brk, hov, aln;
  int mdl[5];
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 ref_clk = ~ref_clk;
  msor_host i_host (.ref_clk(ref_clk), .reg_addr(ra), .reg_write(rw), .reg_wdata(wd),
    .reg_rdata(rdat));
  msor_option_regs i_dut (.ref_clk(ref_clk), .reset(reset), .reg_addr(ra), .reg_write(rw),
    .reg_wdata(wd), .reg_rdata(rdat), .reg_hit(hit), .stationary_judge_window(sjw),
    .stationary_window_ms(win), .sense_advance_angle(saa), .sense_advance_degrees(deg),
    .initial_speed_detect_enable(initial_speed_detection), .reverse_drive_enable(rde),
    .reverse_drive_threshold(rdt), .open_loop_current(olc), .open_loop_ramp_rate(olr),
    .brake_duration(bd), .brake_enable(be), .brake_duration_ms(brk),
    .control_coefficient(cc), .startup_accel_second_order(sa2),
    .startup_accel_first_order(sa1), .handover_threshold(ht), .handover_freq_dhz(hov),
    .handover_valid(hv), .align_duration(ad), .align_duration_ms(aln),
    .no_motor_fault_enable(nm), .fault_detect_enables(fde),
    .inductive_surge_protect_enable(ise), .mechanical_surge_protect_enable(mse),
    .mechanical_surge_protect_limit(msl), .sense_release_state(srs));
  // ----
  // checking helpers
  // ----
  function automatic msor_byte_t fld(input int i);
    case (i)
      0: return {sjw, saa, initial_speed_detection, rde, rdt};
      1: return {olc, olr, bd};
      2: return {cc, sa2, sa1};
      3: return {ht, ad};
      default: return {nm, fde, ise, mse, msl, srs};
    endcase
  endfunction : fld
  task automatic chk(input msor_word_t got, input msor_word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_all();
    msor_byte_t d;
    for (int i = 0; i < 5; i++)
    begin
      i_host.rd(8'h23 + 8'(i), d);
      chk({8'h00, d}, 16'(mdl[i][7:0]));
      chk({8'h00, fld(i)}, 16'(mdl[i][7:0]));
      chk({15'h0000, hit}, 16'h0001);
    end
  endtask : chk_all
  task automatic conclude();
    $display("compared=%0d failures=%0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      failures++;
      conclude();
    end
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    msor_byte_t b;
    msor_byte_t d;
    int k;
    void'($urandom(32'hc108));
    repeat (20) @(posedge ref_clk);
    @(negedge ref_clk) reset = 1'b0;
    chk_all();
    for (int c = 0; c < 32; c++)
    begin
      b = {c[4:0], c[2:0]};
      for (int j = 0; j < 4; j++)
      begin
        i_host.wr(8'h23 + 8'(j), b);
        mdl[j] = b;
      end
      chk(win, 16'h0050 << b[7:6]);
      chk({8'h00, deg}, 16'h001E * (b[5:4] + 16'h0001));
      chk(brk, (b[2:0] == 3'h0) ? 16'h0000 : 16'h0A8C >> (b[2:0] - 3'h1));
      chk({15'h0000, be}, {15'h0000, b[2:0] != 3'h0});
      chk(hov, b[7] ? (b[6:3] + 16'h0001) * 16'h0080 : b[6:3] * 16'h0008);
      chk({15'h0000, hv}, {15'h0000, b[7:3] != 5'h00});
      chk(aln, 16'h14B4 >> b[2:0]);
    end
    repeat (40)
    begin
      k = $urandom % 6;
      b = 8'($urandom);
      i_host.wr((k < 5) ? 8'h23 + 8'(k) : 8'h28, b);
      if (k < 5)
        mdl[k] = b;
      i_host.rd((k < 5) ? 8'h23 + 8'(k) : 8'h28, d);
      chk({8'h00, d}, (k < 5) ? {8'h00, b} : 16'h0000);
      chk({15'h0000, hit}, {15'h0000, k < 5});
    end
    chk_all();
    @(negedge ref_clk) reset = 1'b1;
    repeat (2) @(negedge ref_clk);
    reset = 1'b0;
    mdl = '{default: 0};
    chk_all();
    chk(win, 16'h0050);
    chk({8'h00, deg}, 16'h001e);
    chk(aln, 16'h14b4);
    chk({15'h0000, hv}, 16'h0000);
    conclude();
  end
endmodule : testbench
bind msor_option_regs msor_props i_props (
  .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
  .brake_duration(brake_duration), .brake_enable(brake_enable),
  .handover_threshold(handover_threshold), .handover_valid(handover_valid),
  .align_duration(align_duration), .no_motor_fault_enable(no_motor_fault_enable),
  .fault_detect_enables(fault_detect_enables),
  .inductive_surge_protect_enable(inductive_surge_protect_enable),
  .mechanical_surge_protect_enable(mechanical_surge_protect_enable),
  .mechanical_surge_protect_limit(mechanical_surge_protect_limit),
  .sense_release_state(sense_release_state));
`default_nettype wire
